// ===== pcie_lss_pkg.sv
`default_nettype none
package pcie_lss_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] LINK_CTL_IDX = 10'h050;
  localparam logic [9:0] LINK_STS_IDX = 10'h052;
  localparam logic [9:0] SLOT_CAP_IDX = 10'h054;
  localparam logic [9:0] CFG_IDX      = 10'h060;
  // link control field positions
  localparam int unsigned RETRAIN_BIT = 5;
  localparam int unsigned AWB_BIT     = 9;
  localparam int unsigned BWM_EN_BIT  = 10;
  localparam int unsigned ABW_EN_BIT  = 11;
  // link status field positions
  localparam int unsigned SHCLK_BIT    = 12;
  localparam int unsigned BWM_FLAG_BIT = 14;
  localparam int unsigned ABW_FLAG_BIT = 15;
  // values after reset, speed codes and sizes
  localparam logic [3:0] SPEED_RST  = 4'h1;
  localparam logic [3:0] SPEED_GEN1 = 4'h1;
  localparam logic [3:0] SPEED_GEN2 = 4'h2;
  localparam logic [5:0] WIDTH_INIT = 6'h01;
  localparam logic [6:0] CFG_RST    = 7'h2e;
  localparam int unsigned SLOT_CAP_W = 6;
  localparam int unsigned TS_RUN_LEN = 8;
  localparam int unsigned SYNC_DEPTH = 2;

  typedef struct packed {
    logic       auto_bw;
    logic       bw_mgmt;
    logic       dl_active;
    logic       shared_clk;
    logic       training;
    logic       train_fail;
    logic [5:0] width;
    logic [3:0] speed;
  } link_status_t;

  typedef struct packed {
    logic upstream_port;
    logic lock_open;
    logic legacy_1_0a;
    logic slot_impl;
    logic dll_capable;
    logic bw_notify_capable;
    logic compat_1_1;
  } cfg_t;

  typedef struct packed {
    logic [3:0] speed;
    logic [5:0] width;
    logic       training;
    logic       train_err;
    logic       dl_active;
  } phy_status_t;

  typedef struct packed {
    logic retrain_done;
    logic reliab_change;
    logic auto_change;
  } phy_event_t;

  typedef struct packed {
    logic valid;
    logic is_ts;
    logic auto_bit;
  } ord_set_t;
endpackage
`default_nettype wire

// ===== sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_2ff
  import pcie_lss_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta[i] <= 1'b0;
        q_o[i]  <= 1'b0;
      end else begin
        meta[i] <= d_i[i];
        q_o[i]  <= meta[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== ts_run_detect.sv
`timescale 1ns/1ps
`default_nettype none
module ts_run_detect
  import pcie_lss_pkg::*;
#(
  parameter int unsigned RUN_LEN = TS_RUN_LEN
) (
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  input  wire ord_set_t os_i,
  output logic          hit_o
);
  localparam int unsigned CW = $clog2(RUN_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(RUN_LEN - 1);
  localparam logic [CW-1:0] FULL = CW'(RUN_LEN);

  logic [CW-1:0] count;

  // saturates at the run length so one run reports once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (os_i.valid && os_i.is_ts) begin
      if (!os_i.auto_bit) begin
        count <= '0;
      end else if (count != FULL) begin
        count <= count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= os_i.valid && os_i.is_ts && os_i.auto_bit && count == LAST;
    end
  end
endmodule
`default_nettype wire

// ===== pcie_link_status_slot_cap_regs.sv
// Function
// - width block bit stops autonomous widening
// - 1.1 mode: bandwidth bits read zero
// - bandwidth management enable raises interrupt
// - autonomous bandwidth enable raises interrupt
// - no notification capability: bandwidth bits zero
// - speed resets 1, reports 1 or 2
// - width field reports negotiated lane count
// - training flag follows training in progress
// - shared clock bit loads from straps
// - link active flag, zero without capability
// - retrain done or reliability change sets flag
// - autonomous change sets autonomous flag
// - slot bits 0..4 feature presence, reset zero
// - slot bit 5 allows surprise removal
// - no slot: slot capability reads zero
// - retrain write sends physical layer recovery
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pcie_link_status_slot_cap_regs
  import pcie_lss_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire phy_status_t phy_status_i,
  input  wire phy_event_t  phy_event_i,
  input  wire ord_set_t    ord_set_i,
  input  wire logic        upstream_common_clock_in_i,
  input  wire logic        downstream_common_clock_in_i,
  output logic             autonomous_width_block_o,
  output logic             retrain_request_o,
  output logic             irq_o
);
  typedef enum logic [1:0] {CLK_WAIT0, CLK_WAIT1, CLK_LOAD, CLK_DONE} strap_t;

  logic         rst_meta;
  logic         rst_n;
  cfg_t         cfg;
  link_status_t sts;
  logic         awb;
  logic         bwm_en;
  logic         abw_en;
  logic [SLOT_CAP_W-1:0] slot_cap;
  logic [1:0]   strap_s;
  strap_t       strap_state;
  logic         ts_hit;
  logic         setup;
  logic         wr_acc;
  logic         bw_ok;
  logic         bwm_set;
  logic         abw_set;
  logic         bwm_clr;
  logic         abw_clr;
  logic [31:0]  next_rdata;
  logic         next_err;
  link_status_t sts_rd;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  sync_2ff #(
    .WIDTH(2)
  ) u_strap_sync (
    .clk_i  (clk_i),
    .rst_n_i(rst_n),
    .d_i    ({upstream_common_clock_in_i, downstream_common_clock_in_i}),
    .q_o    (strap_s)
  );

  ts_run_detect #(
    .RUN_LEN(TS_RUN_LEN)
  ) u_ts_run (
    .clk_i  (clk_i),
    .rst_n_i(rst_n),
    .os_i   (ord_set_i),
    .hit_o  (ts_hit)
  );

  assign setup    = psel_i && !penable_i;
  assign wr_acc   = psel_i && penable_i && pwrite_i;
  assign pready_o = 1'b1;
  // both 1.1 compatibility and missing capability gate the bandwidth bits
  assign bw_ok    = cfg.bw_notify_capable && !cfg.compat_1_1;

  // dl_active qualifier keeps bandwidth management events seen across DL_Down out
  assign bwm_set = bw_ok && phy_status_i.dl_active
                   && (phy_event_i.retrain_done
                       || phy_event_i.reliab_change);
  assign abw_set = bw_ok && (phy_event_i.auto_change
                   || (!cfg.upstream_port && ts_hit));
  assign bwm_clr = wr_acc && paddr_i[11:2] == LINK_STS_IDX
                   && pwdata_i[BWM_FLAG_BIT];
  assign abw_clr = wr_acc && paddr_i[11:2] == LINK_STS_IDX
                   && pwdata_i[ABW_FLAG_BIT];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= cfg_t'(CFG_RST);
    end else if (wr_acc && paddr_i[11:2] == CFG_IDX) begin
      cfg <= cfg_t'(pwdata_i[6:0]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      awb    <= 1'b0;
      bwm_en <= 1'b0;
      abw_en <= 1'b0;
    end else if (wr_acc && paddr_i[11:2] == LINK_CTL_IDX) begin
      awb    <= pwdata_i[AWB_BIT] && !cfg.compat_1_1;
      bwm_en <= pwdata_i[BWM_EN_BIT] && bw_ok;
      abw_en <= pwdata_i[ABW_EN_BIT] && bw_ok;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      retrain_request_o <= 1'b0;
    end else begin
      retrain_request_o <= wr_acc && paddr_i[11:2] == LINK_CTL_IDX
                           && pwdata_i[RETRAIN_BIT];
    end
  end

  // physical layer honours the block by narrowing only
  assign autonomous_width_block_o = awb && !cfg.compat_1_1;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sts.speed <= SPEED_RST;
    end else if (phy_status_i.speed == SPEED_GEN1
                 || phy_status_i.speed == SPEED_GEN2) begin
      sts.speed <= phy_status_i.speed;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sts.width      <= WIDTH_INIT;
      sts.training   <= 1'b0;
      sts.train_fail <= 1'b0;
      sts.dl_active  <= 1'b0;
    end else begin
      sts.width      <= phy_status_i.width;
      sts.training   <= phy_status_i.training;
      sts.train_fail <= phy_status_i.train_err && cfg.legacy_1_0a;
      sts.dl_active  <= phy_status_i.dl_active && cfg.dll_capable;
    end
  end

  // straps wait out the synchroniser before they are trusted
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_state <= CLK_WAIT0;
    end else begin
      case (strap_state)
        CLK_WAIT0: strap_state <= CLK_WAIT1;
        CLK_WAIT1: strap_state <= CLK_LOAD;
        CLK_LOAD:  strap_state <= CLK_DONE;
        CLK_DONE:  strap_state <= CLK_DONE;
        default:   strap_state <= CLK_WAIT0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sts.shared_clk <= 1'b0;
    end else if (strap_state == CLK_LOAD) begin
      sts.shared_clk <= cfg.upstream_port ? strap_s[1] : strap_s[0];
    end else if (wr_acc && paddr_i[11:2] == LINK_STS_IDX && cfg.lock_open) begin
      sts.shared_clk <= pwdata_i[SHCLK_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sts.bw_mgmt <= 1'b0;
      sts.auto_bw <= 1'b0;
    end else begin
      sts.bw_mgmt <= bw_ok && ((sts.bw_mgmt && !bwm_clr) || bwm_set);
      sts.auto_bw <= bw_ok && ((sts.auto_bw && !abw_clr) || abw_set);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slot_cap <= '0;
    end else if (!cfg.slot_impl) begin
      slot_cap <= '0;
    end else if (wr_acc && paddr_i[11:2] == SLOT_CAP_IDX && cfg.lock_open) begin
      slot_cap <= pwdata_i[SLOT_CAP_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (bwm_en && sts.bw_mgmt) || (abw_en && sts.auto_bw);
    end
  end

  always_comb begin
    sts_rd         = sts;
    sts_rd.bw_mgmt = sts.bw_mgmt && bw_ok;
    sts_rd.auto_bw = sts.auto_bw && bw_ok;
    next_err       = 1'b0;
    next_rdata     = 32'h0000_0000;
    case (paddr_i[11:2])
      LINK_CTL_IDX: begin
        next_rdata[AWB_BIT]    = awb && !cfg.compat_1_1;
        next_rdata[BWM_EN_BIT] = bwm_en && bw_ok;
        next_rdata[ABW_EN_BIT] = abw_en && bw_ok;
      end
      LINK_STS_IDX: begin
        next_rdata[15:0] = sts_rd;
      end
      SLOT_CAP_IDX: begin
        next_rdata[SLOT_CAP_W-1:0] = cfg.slot_impl ? slot_cap : '0;
      end
      CFG_IDX: begin
        next_rdata[6:0] = cfg;
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // answer is prepared at setup so data leaves a flop
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
      pslverr_o <= next_err;
    end
  end

  a_retrain_pulse: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_acc && paddr_i[11:2] == LINK_CTL_IDX && pwdata_i[RETRAIN_BIT])
    |=> retrain_request_o ##1 !retrain_request_o || $past(wr_acc))
    else $error("retrain write gave no pulse");

  a_bw_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n)
    (bwm_set && bwm_clr) |=> sts.bw_mgmt)
    else $error("clear beat a bandwidth event");

  a_compat_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
    $past(cfg.compat_1_1) && cfg.compat_1_1
    |-> !sts.bw_mgmt && !sts.auto_bw && !autonomous_width_block_o)
    else $error("bandwidth bits live in 1.1 mode");

  a_speed_legal: assert property (@(posedge clk_i) disable iff (!rst_n)
    sts.speed == SPEED_GEN1 || sts.speed == SPEED_GEN2)
    else $error("reserved speed code shown");

  a_training_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
    phy_status_i.training |=> sts.training)
    else $error("training flag lags");

  a_dll_gate: assert property (@(posedge clk_i) disable iff (!rst_n)
    !$past(cfg.dll_capable) |-> !sts.dl_active)
    else $error("link active without capability");

  a_slot_masked: assert property (@(posedge clk_i) disable iff (!rst_n)
    !$past(cfg.slot_impl) |-> slot_cap == '0)
    else $error("slot bits set without slot");

  a_irq_cause: assert property (@(posedge clk_i) disable iff (!rst_n)
    (bwm_en && sts.bw_mgmt) |=> irq_o)
    else $error("bandwidth interrupt missing");

  a_ts_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    (ts_hit && !cfg.upstream_port && bw_ok) |=> sts.auto_bw)
    else $error("TS run did not set flag");
endmodule
`default_nettype wire

// ===== link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner
  import pcie_lss_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  retrain_request_i,
  output phy_status_t phy_status_o,
  output phy_event_t  phy_event_o,
  output ord_set_t    ord_set_o
);
  phy_status_t st = '{speed: 4'h1, width: 6'h01, default: 1'b0};
  phy_event_t  ev = '0;
  ord_set_t    os = '0;
  logic [4:0]  train_len = 5'h0c;
  logic [4:0]  cnt = '0;
  logic        done = 1'b0;
  logic        tog = 1'b0;
  // retrain walks the link through recovery, then reports done
  always @(posedge clk_i) begin
    tog <= ~tog;
    done <= (cnt == 5'h01);
    if (retrain_request_i)
      cnt <= train_len;
    else if (cnt != '0)
      cnt <= cnt - 5'h01;
  end
  assign phy_status_o = st | {10'h000, cnt != '0, 2'b00};
  assign phy_event_o = ev | {done, 2'b00};
  // idle cycles carry no stable marker bits
  assign ord_set_o = os.valid ? os : {1'b0, tog, ~tog};
  task automatic fire(input phy_event_t e);
    ev <= e;
    @(posedge clk_i);
    ev <= '0;
    @(posedge clk_i);
  endtask
  // marked sets announce an autonomous change
  task automatic send_ts(input int n, input logic mark);
    repeat (n) begin
      os <= '{valid: 1'b1, is_ts: 1'b1, auto_bit: mark};
      @(posedge clk_i);
    end
    os.valid <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import pcie_lss_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        up_cc = 1'b0;
  logic        dn_cc = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serr;
  logic [31:0] rdata;
  phy_status_t phy_st;
  phy_event_t  phy_ev;
  ord_set_t    os;
  logic        awb;
  logic        rtr;
  logic        irq;
  int          n_errors = 0;
  int          checks = 0;
  int          n_rtr = 0;

  pcie_link_status_slot_cap_regs u_pcie_link_status_slot_cap_regs (
    .clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .phy_status_i(phy_st), .phy_event_i(phy_ev), .ord_set_i(os),
    .upstream_common_clock_in_i(up_cc),
    .downstream_common_clock_in_i(dn_cc),
    .autonomous_width_block_o(awb), .retrain_request_o(rtr), .irq_o(irq));
  link_partner u_link_partner (
    .clk_i(clk), .retrain_request_i(rtr), .phy_status_o(phy_st),
    .phy_event_o(phy_ev), .ord_set_o(os));

  initial begin
    forever #50 clk = ~clk;
  end

  // counts retrain pulses as the partner would see them
  always @(posedge clk) begin
    if (rtr === 1'b1)
      n_rtr++;
  end

  task automatic finish_test();
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic chk_reg(input logic [9:0] idx, input logic [31:0] m,
                         input logic [31:0] e);
    apb(1'b0, idx, '0);
    `CHK(rdata & m, e)
  endtask

  // status reads take three cycles, so a fast bit may slip between
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, LINK_STS_IDX, '0);
      n++;
    end while (rdata[b] !== v && n < 20);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clk);
    `CHK(irq, e)
    @(posedge clk);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    chk_reg(LINK_CTL_IDX, '1, '0);
    chk_reg(LINK_STS_IDX, '1,
            {19'h0, 1'b1, 2'b00, WIDTH_INIT, SPEED_RST});
    chk_reg(SLOT_CAP_IDX, '1, '0);
    chk_reg(CFG_IDX, '1, {25'h0, CFG_RST});
    apb(1'b0, 10'h3ff, '0);
    `CHK({serr, rdata}, 33'h1_0000_0000)
  endtask

  task automatic t_ctl();
    wr(LINK_CTL_IDX, 32'h0000_fe00);
    chk_reg(LINK_CTL_IDX, 32'hffff_fe20, 32'h0e00);
    `CHK(awb, 1'b1)
    wr(LINK_CTL_IDX, 32'h0c00);
    `CHK(awb, 1'b0)
    `CHK(n_rtr, 0)
  endtask

  task automatic t_retrain();
    u_link_partner.st.dl_active <= 1'b1;
    wr(LINK_CTL_IDX, 32'h0c20);
    poll(11, 1'b1);
    `CHK(rdata[11], 1'b1)
    `CHK(n_rtr, 1)
    poll(14, 1'b1);
    `CHK(rdata[15:11], 5'b01110)
    chk_irq(1'b1);
    wr(LINK_STS_IDX, 32'h1000);
    chk_reg(LINK_STS_IDX, 32'hc000, 32'h4000);
    wr(LINK_STS_IDX, 32'h5000);
    chk_reg(LINK_STS_IDX, 32'hc000, 32'h0);
    chk_irq(1'b0);
  endtask

  task automatic t_events();
    u_link_partner.st.dl_active <= 1'b0;
    settle();
    u_link_partner.fire(3'b010);
    chk_reg(LINK_STS_IDX, 32'hc000, 32'h0);
    u_link_partner.st.dl_active <= 1'b1;
    settle();
    u_link_partner.fire(3'b010);
    chk_reg(LINK_STS_IDX, 32'hc000, 32'h4000);
    wr(LINK_STS_IDX, 32'h5000);
    u_link_partner.fire(3'b001);
    chk_reg(LINK_STS_IDX, 32'hc000, 32'h8000);
    chk_irq(1'b1);
    wr(LINK_CTL_IDX, 32'h0);
    chk_irq(1'b0);
    wr(LINK_STS_IDX, 32'h9000);
    u_link_partner.send_ts(7, 1'b1);
    u_link_partner.send_ts(1, 1'b0);
    chk_reg(LINK_STS_IDX, 32'h8000, 32'h0);
    u_link_partner.send_ts(8, 1'b1);
    chk_reg(LINK_STS_IDX, 32'h8000, 32'h8000);
    wr(LINK_STS_IDX, 32'h9000);
  endtask

  task automatic t_gate();
    wr(CFG_IDX, 32'h2f);
    wr(LINK_CTL_IDX, 32'h0e00);
    chk_reg(LINK_CTL_IDX, 32'h0e00, 32'h0);
    u_link_partner.fire(3'b001);
    chk_reg(LINK_STS_IDX, 32'hc000, 32'h0);
    wr(CFG_IDX, 32'h2c);
    wr(LINK_CTL_IDX, 32'h0c00);
    chk_reg(LINK_CTL_IDX, 32'h0c00, 32'h0);
    u_link_partner.fire(3'b010);
    chk_reg(LINK_STS_IDX, 32'hc000, 32'h0);
    wr(CFG_IDX, 32'h2a);
    chk_reg(LINK_STS_IDX, 32'h2000, 32'h0);
    wr(CFG_IDX, 32'h2e);
    chk_reg(LINK_STS_IDX, 32'h2000, 32'h2000);
  endtask

  task automatic t_status();
    u_link_partner.st.speed <= SPEED_GEN2;
    u_link_partner.st.width <= 6'h08;
    settle();
    chk_reg(LINK_STS_IDX, 32'h3ff, {22'h0, 6'h08, SPEED_GEN2});
    u_link_partner.st.speed <= 4'h5;
    settle();
    chk_reg(LINK_STS_IDX, 32'hf, {28'h0, SPEED_GEN2});
    u_link_partner.st.speed <= SPEED_GEN1;
    u_link_partner.st.train_err <= 1'b1;
    wr(CFG_IDX, 32'h3e);
    chk_reg(LINK_STS_IDX, 32'h40f, {21'h0, 1'b1, 6'h0, SPEED_GEN1});
    wr(CFG_IDX, 32'h2e);
    chk_reg(LINK_STS_IDX, 32'h400, 32'h0);
  endtask

  task automatic t_slot();
    wr(SLOT_CAP_IDX, '1);
    chk_reg(SLOT_CAP_IDX, '1, 32'h3f);
    wr(CFG_IDX, 32'h0e);
    wr(SLOT_CAP_IDX, '0);
    wr(LINK_STS_IDX, 32'h0);
    chk_reg(SLOT_CAP_IDX, '1, 32'h3f);
    chk_reg(LINK_STS_IDX, 32'h1000, 32'h1000);
    wr(CFG_IDX, 32'h06);
    chk_reg(SLOT_CAP_IDX, '1, '0);
  endtask

  // second reset with swapped straps: downstream port must take its own pin
  task automatic t_strap();
    up_cc <= 1'b1;
    dn_cc <= 1'b0;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    chk_reg(LINK_STS_IDX, 32'h1000, 32'h0);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_ctl();
    t_retrain();
    t_events();
    t_gate();
    t_status();
    t_slot();
    t_strap();
    finish_test();
  end
endmodule
`default_nettype wire
